// file: hw/qdac_pkg.sv
package qdac_pkg;

  // ==========================================================
  // Widths and counts
  localparam int QD_WORD_W = 16;
  localparam int QD_CODE_W = 12;
  localparam int QD_CHANS = 4;
  localparam int QD_PINS = 4;
  localparam logic [4:0] QD_BITS_FULL = 5'h10;
  localparam logic [4:0] QD_BITS_RST = 5'h00;

  // ==========================================================
  // Reset values
  localparam logic [15:0] QD_SR_RST = 16'h0000;
  localparam logic [11:0] QD_CODE_RST = 12'h000;
  // Pin order {sck, cs_n, din, load_n}; select and load idle high
  localparam logic [3:0] QD_SYNC_RST = 4'h5;
  localparam logic QD_SCK_PREV_RST = 1'b0;
  localparam logic QD_CS_PREV_RST = 1'b1;
  localparam logic QD_ECHO_IDLE = 1'b1;

  // ==========================================================
  // Pin positions in the synchroniser vector
  localparam int QD_PIN_SCK = 3;
  localparam int QD_PIN_CS = 2;
  localparam int QD_PIN_DIN = 1;
  localparam int QD_PIN_LOAD = 0;

  // ==========================================================
  // Control field codes
  localparam logic [1:0] QD_CTL_SPECIAL = 2'h0;
  localparam logic [1:0] QD_CTL_INPUT = 2'h1;
  localparam logic [1:0] QD_CTL_EDGE = 2'h2;
  localparam logic [1:0] QD_CTL_BOTH = 2'h3;
  localparam logic [1:0] QD_SP_UPDATE_ALL = 2'h2;
  localparam logic [1:0] QD_SP_LOAD_ALL = 2'h3;
  localparam logic [1:0] QD_EDGE_SEL_FALL = 2'h0;
  localparam logic [1:0] QD_EDGE_SEL_RISE = 2'h1;

  // ==========================================================
  // Types
  typedef struct packed {
    logic chan_addr_hi;
    logic chan_addr_lo;
    logic ctrl_hi;
    logic ctrl_lo;
    logic [11:0] code;
  } qdac_word_t;

  typedef enum logic [1:0] {
    QDAC_IDLE = 2'b01,
    QDAC_SHIFT = 2'b10
  } qdac_state_t;

endpackage : qdac_pkg

// file: hw/qdac_sync.sv
`timescale 1ns/1ps
module qdac_sync
  import qdac_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ==========================================================
  // Two stages; first stage feeds only the second
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= RST;
      sync_q <= RST;
    end else if (ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : qdac_sync

// file: hw/qdac_load.sv
`timescale 1ns/1ps
// What this block does
// RULE1 - 16-bit shift register samples data on shift clock rise, select low
// RULE2 - Shifting and echo output enabled only while select is low
// RULE3 - Select rise moves word into addressed input/converter registers
// RULE4 - Load pin low copies every input register into its converter register
// RULE5 - Echo output shows the last shift register stage
// RULE6 - Select high: echo output released and held high
// RULE7 - Four channels, each an input register feeding a converter register
// RULE8 - Echo changes on shift clock fall or rise per selected mode
// RULE9 - Shift clock edges coinciding with select edges are ignored
// RULE10 - Converter codes are unsigned straight binary, 0 to 4095
// RULE11 - Host sends 16 bits MSB first, select low until all shifted
// RULE12 - Word is address, control, then 12-bit code; these pick the action
// RULE13 - Echo lags 16 cycles rising mode, 16.5 falling; rising after reset
// RULE14 - Load pin low makes converter registers transparent
// RULE15 - Reset clears input, converter and shift registers
// RULE16 - Words shorter than sixteen bits are discarded at select rise
module qdac_load
  import qdac_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic serial_in_pin,
  input wire logic load_all_n,
  output logic serial_echo_out,
  output logic serial_echo_oe,
  output logic echo_on_fall,
  output logic [QD_CHANS-1:0][QD_CODE_W-1:0] dac_code
);

  // ==========================================================
  // Pin synchronisers
  logic [QD_PINS-1:0] pins_s;

  qdac_sync #(.W(QD_PINS), .RST(QD_SYNC_RST)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .async_in({sck, cs_n, serial_in_pin, load_all_n}),
    .sync_out(pins_s)
  );

  logic sck_s;
  logic cs_s;
  logic din_s;
  logic load_s;
  assign sck_s = pins_s[QD_PIN_SCK];
  assign cs_s = pins_s[QD_PIN_CS];
  assign din_s = pins_s[QD_PIN_DIN];
  assign load_s = pins_s[QD_PIN_LOAD];

  // ==========================================================
  // Edge detection
  logic sck_prev_q;
  logic sck_prev_d;
  logic cs_prev_q;
  logic cs_prev_d;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;

  always_comb begin
    sck_prev_d = sck_s;
    cs_prev_d = cs_s;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sck_prev_q <= QD_SCK_PREV_RST;
      cs_prev_q <= QD_CS_PREV_RST;
    end else if (ce) begin
      sck_prev_q <= sck_prev_d;
      cs_prev_q <= cs_prev_d;
    end
  end

  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign cs_rise = cs_s & ~cs_prev_q;
  assign cs_fall = ~cs_s & cs_prev_q;

  // ==========================================================
  // Serial front end
  qdac_state_t state_q;
  qdac_state_t state_d;
  logic [QD_WORD_W-1:0] sr_q;
  logic [QD_WORD_W-1:0] sr_d;
  logic [4:0] bits_q;
  logic [4:0] bits_d;
  logic shift_en;
  logic latch;

  // Select must be low on both sides of the clock edge, so an
  // edge landing with a select transition is dropped
  assign shift_en = (state_q == QDAC_SHIFT) && !cs_s && !cs_prev_q
                    && sck_rise; // RULE9 RULE2
  assign latch = (state_q == QDAC_SHIFT) && cs_s
                 && (bits_q == QD_BITS_FULL); // RULE16

  always_comb begin
    state_d = state_q;
    sr_d = sr_q;
    bits_d = bits_q;
    unique case (state_q)
      QDAC_IDLE: begin
        bits_d = QD_BITS_RST;
        if (!cs_s) begin
          state_d = QDAC_SHIFT;
        end
      end
      QDAC_SHIFT: begin
        if (cs_s) begin
          state_d = QDAC_IDLE;
          bits_d = QD_BITS_RST;
        end else if (shift_en) begin
          sr_d = {sr_q[QD_WORD_W-2:0], din_s}; // RULE1 RULE11
          // Saturate: daisy-chained words keep the last sixteen bits
          if (bits_q != QD_BITS_FULL) begin
            bits_d = bits_q + 5'h01;
          end
        end
      end
      default: begin
        state_d = QDAC_IDLE;
        bits_d = QD_BITS_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= QDAC_IDLE;
      sr_q <= QD_SR_RST; // RULE15
      bits_q <= QD_BITS_RST;
    end else if (ce) begin
      state_q <= state_d;
      sr_q <= sr_d;
      bits_q <= bits_d;
    end
  end

  // ==========================================================
  // Echo output
  logic echo_q;
  logic echo_d;
  logic oe_q;
  logic oe_d;
  logic fall_mode_q;
  logic fall_mode_d;

  always_comb begin
    echo_d = echo_q;
    oe_d = !cs_s; // RULE2
    if (cs_s) begin
      echo_d = QD_ECHO_IDLE; // RULE6
    end else if (cs_fall) begin
      echo_d = sr_q[QD_WORD_W-1];
    end else if (!fall_mode_q && shift_en) begin
      echo_d = sr_d[QD_WORD_W-1]; // RULE5 RULE8 RULE13
    end else if (fall_mode_q && sck_fall) begin
      echo_d = sr_q[QD_WORD_W-1]; // RULE8 RULE13
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      echo_q <= QD_ECHO_IDLE;
      oe_q <= 1'b0;
    end else if (ce) begin
      echo_q <= echo_d;
      oe_q <= oe_d;
    end
  end

  assign serial_echo_out = echo_q;
  assign serial_echo_oe = oe_q;

  // ==========================================================
  // Double-buffered channel registers
  logic [QD_CHANS-1:0][QD_CODE_W-1:0] in_q;
  logic [QD_CHANS-1:0][QD_CODE_W-1:0] in_d;
  logic [QD_CHANS-1:0][QD_CODE_W-1:0] conv_q;
  logic [QD_CHANS-1:0][QD_CODE_W-1:0] conv_d;
  qdac_word_t word;
  logic [1:0] addr;
  logic [1:0] ctl;

  assign word = qdac_word_t'(sr_q); // RULE12
  assign addr = {word.chan_addr_hi, word.chan_addr_lo};
  assign ctl = {word.ctrl_hi, word.ctrl_lo};

  always_comb begin
    in_d = in_q;
    conv_d = conv_q;
    fall_mode_d = fall_mode_q;
    if (latch) begin // RULE3
      unique case (ctl)
        QD_CTL_INPUT: in_d[addr] = word.code;
        QD_CTL_BOTH: begin
          in_d[addr] = word.code;
          conv_d[addr] = word.code;
        end
        QD_CTL_SPECIAL: begin
          if (addr == QD_SP_UPDATE_ALL) begin
            conv_d = in_q;
          end else if (addr == QD_SP_LOAD_ALL) begin
            for (int i = 0; i < QD_CHANS; i++) begin
              in_d[i] = word.code;
              conv_d[i] = word.code;
            end
          end
        end
        QD_CTL_EDGE: begin
          // Edge change also refreshes every converter register
          if (addr == QD_EDGE_SEL_FALL || addr == QD_EDGE_SEL_RISE) begin
            fall_mode_d = (addr == QD_EDGE_SEL_FALL); // RULE8
            conv_d = in_q;
          end
        end
      endcase
    end
    // Sampled, not truly asynchronous: costs up to three clocks
    if (!load_s) begin
      conv_d = in_d; // RULE4 RULE14
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_q <= {QD_CHANS{QD_CODE_RST}}; // RULE15
      conv_q <= {QD_CHANS{QD_CODE_RST}};
      fall_mode_q <= 1'b0; // RULE13
    end else if (ce) begin
      in_q <= in_d; // RULE7
      conv_q <= conv_d;
      fall_mode_q <= fall_mode_d;
    end
  end

  assign dac_code = conv_q; // RULE10
  assign echo_on_fall = fall_mode_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  shift_on_rise_a: assert property ( // RULE1
    ce && shift_en |=> sr_q == {$past(sr_q[14:0]), $past(din_s)})
    else $error("shift register did not take data bit");

  no_shift_high_a: assert property ( // RULE2
    ce && cs_s |=> $stable(sr_q))
    else $error("shift register moved with select high");

  echo_idle_high_a: assert property ( // RULE6
    ce && cs_s |=> serial_echo_out && !serial_echo_oe)
    else $error("echo not released high with select high");

  latch_input_a: assert property ( // RULE3
    ce && latch && ctl == QD_CTL_INPUT
    |=> in_q[$past(addr)] == $past(word.code))
    else $error("input register not loaded at select rise");

  partial_word_a: assert property ( // RULE16
    ce && cs_rise && bits_q != QD_BITS_FULL |=> $stable(in_q))
    else $error("partial word changed input registers");

  load_copy_a: assert property ( // RULE4
    ce && !load_s && !latch |=> conv_q == $past(in_q))
    else $error("load pin did not copy input registers");

  reset_state_a: assert property ( // RULE15
    $rose(nrst) |-> !echo_on_fall && conv_q == '0 && in_q == '0)
    else $error("reset values wrong");

  fall_mode_hold_a: assert property ( // RULE8
    ce && fall_mode_q && shift_en && !cs_fall
    |=> $stable(serial_echo_out))
    else $error("echo moved on rise in falling mode");

  rise_mode_echo_a: assert property ( // RULE5
    ce && !fall_mode_q && shift_en |=> serial_echo_out == sr_q[15])
    else $error("echo not last stage in rising mode");

  cs_edge_skip_a: assert property ( // RULE9
    ce && cs_fall && sck_rise |=> $stable(sr_q))
    else $error("clock edge at select fall was taken");

endmodule : qdac_load

// file: test/qdac_host.sv
`timescale 1ns/1ps
module qdac_host (
  input wire logic clk,
  input wire logic echo_pin,
  output logic sck,
  output logic cs_n,
  output logic din
);
  // ====================================
  // Idle pins: clock parked low, select high
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // ====================================
  // Link timing, 8 clk per sck period
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Echo sampled just before each sck fall, so the two modes differ
  task automatic xfer(input logic [15:0] w, input int n, input logic sel,
                      input logic skew, output logic [15:0] cap);
    cap = 16'h0000;
    // Skewed frames raise the clock together with each select edge
    cs_n = ~sel;
    sck = skew;
    tick(4);
    sck = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = w[15-i];
      tick(4);
      sck = 1'b1;
      tick(4);
      cap[15-i] = echo_pin;
      sck = 1'b0;
    end
    tick(4);
    // Released data line must not keep its last value
    din = ~din;
    sck = skew;
    cs_n = 1'b1;
    tick(5);
    sck = 1'b0;
    tick(1);
  endtask : xfer
endmodule : qdac_host

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  import qdac_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic load_all_n = 1'b1;
  logic sck, cs_n, din, echo_out, echo_oe, on_fall, echo_pin;
  logic [QD_CHANS-1:0][QD_CODE_W-1:0] dac;
  logic [15:0] cap;
  logic [15:0] last_sr = 16'h0000;
  logic fall_mode = 1'b0;
  logic skew = 1'b0;
  logic [11:0] codes [4] = '{12'hfff, 12'h001, 12'h800, 12'h7fe};
  int failures = 0;
  int num_checks = 0;

  always #10 clk = ~clk;
  // Pull-up on the echo pin while it is not driven
  assign echo_pin = echo_oe ? echo_out : 1'b1;

  qdac_load uut (.clk(clk), .nrst(nrst), .ce(1'b1), .sck(sck), .cs_n(cs_n),
    .serial_in_pin(din), .load_all_n(load_all_n),
    .serial_echo_out(echo_out), .serial_echo_oe(echo_oe),
    .echo_on_fall(on_fall), .dac_code(dac));
  qdac_host host (.clk(clk), .echo_pin(echo_pin), .sck(sck),
    .cs_n(cs_n), .din(din));

  // ====================================
  // Checks and frames
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input logic [15:0] w, input int n);
    logic [15:0] exp_cap;
    exp_cap = fall_mode ? last_sr : {last_sr[14:0], w[15]};
    host.xfer(w, n, 1'b1, skew, cap);
    if (n == 16) chk(cap, exp_cap);
    last_sr = (n == 16) ? w : {last_sr[7:0], w[15:8]};
    chk({14'h0, echo_out, echo_oe}, 16'h0002);
  endtask : send

  task automatic end_sim;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // ====================================
  // Watchdog, about four and a half times the expected run
  initial begin
    #200000;
    failures++;
    end_sim();
  end

  // ====================================
  // Tests
  initial begin
    host.tick(4);
    nrst = 1'b1;
    host.tick(3);
    for (int i = 0; i < 4; i++) chk(16'(dac[i]), 16'h0000);
    chk({13'h0, echo_out, echo_oe, on_fall}, 16'h0004);
    for (int i = 0; i < 4; i++) begin
      send({2'(i), QD_CTL_BOTH, codes[i]}, 16);
      chk(16'(dac[i]), 16'(codes[i]));
    end
    send({2'h1, QD_CTL_INPUT, 12'habc}, 16);
    chk(16'(dac[1]), 16'(codes[1]));
    send({QD_EDGE_SEL_FALL, QD_CTL_EDGE, 12'h000}, 16);
    fall_mode = 1'b1;
    chk({3'h0, on_fall, dac[1]}, 16'h1abc);
    // From here on a clock edge lands on both select edges
    skew = 1'b1;
    send({2'h0, QD_CTL_SPECIAL, 12'h000}, 16);
    send({QD_EDGE_SEL_RISE, QD_CTL_EDGE, 12'h000}, 16);
    fall_mode = 1'b0;
    chk({3'h0, on_fall, dac[1]}, 16'h0abc);
    send({2'h2, QD_CTL_INPUT, 12'h321}, 16);
    chk(16'(dac[2]), 16'(codes[2]));
    load_all_n = 1'b0;
    host.tick(4);
    load_all_n = 1'b1;
    host.tick(3);
    chk(16'(dac[2]), 16'h0321);
    load_all_n = 1'b0;
    send({2'h3, QD_CTL_INPUT, 12'h456}, 16);
    chk(16'(dac[3]), 16'h0456);
    load_all_n = 1'b1;
    send({QD_SP_LOAD_ALL, QD_CTL_SPECIAL, 12'h9c3}, 16);
    for (int i = 0; i < 4; i++) chk(16'(dac[i]), 16'h09c3);
    send({2'h0, QD_CTL_INPUT, 12'h111}, 16);
    send({QD_SP_UPDATE_ALL, QD_CTL_SPECIAL, 12'h000}, 16);
    chk(16'(dac[0]), 16'h0111);
    // Short word must leave the channel 0 converter register alone
    send({2'h0, QD_CTL_BOTH, 12'h222}, 8);
    chk(16'(dac[0]), 16'h0111);
    host.xfer(16'h0f0f, 16, 1'b0, skew, cap);
    chk(cap, 16'hffff);
    send({2'h0, QD_CTL_SPECIAL, 12'h000}, 16);
    end_sim();
  end
endmodule : tb
